// ---- src/trig_filter_pkg.sv ----
// Shared constants for the trigger input filter and edge trigger block.
package trig_filter_pkg;

  // ==========================================================================
  // Input counts
  localparam int NUM_FN = 16;
  localparam int NUM_BUS = 8;
  localparam int NUM_IN = NUM_FN + NUM_BUS + 1;
  localparam int STAR_IDX = NUM_IN - 1;

  // ==========================================================================
  // Filter settings and timing
  typedef enum logic [1:0] {FILT_OFF, FILT_SHORT, FILT_MID, FILT_LONG} filt_setting_t;
  localparam int CNT_W = 17;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SHORT_PASS_NS = 125;
  localparam int MID_PASS_NS = 6425;
  localparam int LONG_PASS_NS = 2560000;
  // Guaranteed-pass widths round down so such a pulse always spans N samples.
  localparam logic [CNT_W-1:0] SHORT_CYC = CNT_W'(SHORT_PASS_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MID_CYC = CNT_W'(MID_PASS_NS / CLK_PERIOD_NS);
  localparam int LONG_CYC = LONG_PASS_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_FILT_FN = 8'h00;
  localparam logic [7:0] OFS_FILT_BUS = 8'h04;
  localparam logic [7:0] OFS_ROUTE_SEL = 8'h08;
  localparam logic [7:0] OFS_ROUTE_EN = 8'h0C;
  localparam logic [7:0] OFS_TRIG_CFG = 8'h10;
  localparam logic [7:0] OFS_TRIG_CMD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_RAW = 8'h1C;

  // ==========================================================================
  // Field layout and reset values
  localparam int FILT_BUS_W = 18;
  localparam int ROUTE_EN_W = 24;
  localparam int TRIG_SRC_LSB = 0;
  localparam int TRIG_FALL_BIT = 5;
  localparam int TRIG_EN_BIT = 6;
  localparam int TRIG_AI_BIT = 7;
  localparam int TRIG_AO_BIT = 8;
  localparam int TRIG_CTR_BIT = 9;
  localparam int TRIG_CFG_W = 10;
  localparam logic [4:0] SRC_STAR = 5'h17;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage

// ---- src/debounce_filter.sv ----
// One debounce filter: N consecutive agreeing samples move the output.
`timescale 1ns/1ns
module debounce_filter #(
  parameter int LONG_CYCLES = trig_filter_pkg::LONG_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw level and its setting.
  input wire logic raw_i,
  input wire logic [1:0] setting_i,
  // Filtered level.
  output logic filt_o
);

  logic [trig_filter_pkg::CNT_W-1:0] cnt;
  logic [trig_filter_pkg::CNT_W-1:0] need;
  logic [trig_filter_pkg::CNT_W-1:0] next_cnt;

  // Sample count needed by the current setting.
  always_comb begin
    case (setting_i)
      trig_filter_pkg::FILT_SHORT: need = trig_filter_pkg::SHORT_CYC;
      trig_filter_pkg::FILT_MID: need = trig_filter_pkg::MID_CYC;
      default: need = trig_filter_pkg::CNT_W'(LONG_CYCLES);
    endcase
  end

  assign next_cnt = trig_filter_pkg::CNT_W'(cnt + 1'b1);

  // Each clock edge is one sample; a sample equal to the output restarts the run.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_o <= 1'b0;
      cnt <= '0;
    end else if (setting_i == trig_filter_pkg::FILT_OFF) begin
      filt_o <= raw_i;
      cnt <= '0;
    end else if (raw_i == filt_o) begin
      cnt <= '0;
    end else if (next_cnt >= need) begin
      filt_o <= raw_i;
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  sequence high_run;
    (setting_i == trig_filter_pkg::FILT_SHORT && !filt_o && raw_i) [*3];
  endsequence
  sequence low_run;
    (setting_i == trig_filter_pkg::FILT_SHORT && filt_o && !raw_i) [*3];
  endsequence

  chk_short_rise_pass: assert property (@(posedge clk_i) disable iff (rst_i) high_run |=> filt_o)
    else $error("short filter did not rise after a stable high run");
  chk_short_fall_pass: assert property (@(posedge clk_i) disable iff (rst_i) low_run |=> !filt_o)
    else $error("short filter did not fall after a stable low run");
  chk_no_early_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(filt_o) && $past(setting_i) == trig_filter_pkg::FILT_SHORT
      && $past(setting_i, 3) == trig_filter_pkg::FILT_SHORT |-> $past(raw_i) && $past(raw_i, 2) && $past(raw_i, 3))
    else $error("short filter rose on fewer than three high samples");
  chk_glitch_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    setting_i != trig_filter_pkg::FILT_OFF && raw_i == filt_o |=> cnt == '0)
    else $error("agreeing sample did not restart the count");

endmodule

// ---- src/trigger_edge_detect.sv ----
// Edge detector that turns a filtered level into a one-cycle trigger.
`timescale 1ns/1ns
module trigger_edge_detect (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Source level and edge choice.
  input wire logic level_i,
  input wire logic fall_i,
  input wire logic en_i,
  // Trigger pulse.
  output logic pulse_o
);

  logic prev;

  // Previous level is tracked even when disabled, so enabling never fires falsely.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      prev <= level_i;
      pulse_o <= en_i && (fall_i ? (prev && !level_i) : (!prev && level_i));
    end
  end

  chk_edge_fires: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && prev != level_i && level_i == !fall_i |=> pulse_o)
    else $error("selected edge did not fire a trigger");
  chk_edge_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    pulse_o |-> $past(en_i) && $past(level_i) == !$past(fall_i) && $changed($past(level_i)))
    else $error("trigger fired without its selected edge");

endmodule

// ---- src/trigger_input_debounce_edge_detect.sv ----
// Trigger input front end: per-input debounce, raw routing and digital edge trigger.
//
// Overview of operation
// - Every function input, bused line and star line has its own optional filter.
// - An enabled filter samples its input on every rising filter clock edge.
// - A rise passes only after N consecutive high samples.
// - A fall passes only after N consecutive low samples.
// - The setting chooses N: short, middle or long sample count.
// - Short setting passes 125 ns pulses and blocks pulses of 80 ns or less.
// - Long setting passes 2.56 ms pulses, blocks 2.54 ms; disabled means no qualification.
// - Filtering adds at most one sample period of edge jitter.
// - Each input keeps its own setting; changing one leaves the others alone.
// - After reset all filters are disabled and pass signals unqualified.
// - Direct routes between function pins and bused lines carry the raw input.
// - The eight chassis trigger lines are the bused trigger lines 0 to 7.
// - The star trigger line is only received, never driven.
// - The star line can be chosen as a trigger source for all targets.
// - Trigger source is any function input or bused lines 0 to 6.
// - The trigger fires on the selected rising or falling edge.
// - Software can trigger too; triggers act on input, output or counters.
`timescale 1ns/1ns
module trigger_input_debounce_edge_detect #(
  parameter int LONG_CYCLES = trig_filter_pkg::LONG_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Function input pins.
  input wire logic [15:0] function_input_i,
  output logic [15:0] function_input_o,
  output logic [15:0] function_input_oe_n_o,
  // Bused trigger lines, shared with the chassis trigger lines.
  input wire logic [7:0] bused_trigger_line_i,
  output logic [7:0] bused_trigger_line_o,
  output logic [7:0] bused_trigger_line_oe_n_o,
  // Star trigger line, receive only.
  input wire logic star_trigger_line_i,
  // Filtered levels for downstream timing logic.
  output logic [15:0] filtered_function_o,
  output logic [7:0] filtered_bused_o,
  output logic filtered_star_o,
  // Trigger pulses to the acquisition, generation and counter engines.
  output logic ai_trigger_o,
  output logic ao_trigger_o,
  output logic ctr_trigger_o
);

  // ==========================================================================
  // Declarations

  logic [31:0] filt_fn;
  logic [trig_filter_pkg::FILT_BUS_W-1:0] filt_bus;
  logic [31:0] route_sel;
  logic [trig_filter_pkg::ROUTE_EN_W-1:0] route_en;
  logic [trig_filter_pkg::TRIG_CFG_W-1:0] trig_cfg;
  logic sw_pulse;
  logic [trig_filter_pkg::NUM_IN-1:0] raw_all;
  logic [trig_filter_pkg::NUM_IN-1:0] filt_all;
  logic [2*trig_filter_pkg::NUM_IN-1:0] setting_all;
  logic req;
  logic wr_now;
  logic [31:0] next_dat;
  logic [4:0] src_code;
  logic src_level;
  logic hw_pulse;

  // ==========================================================================
  // Byte-lane merge for register writes

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = val[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Wishbone handshake

  // A request is live while cycle and strobe are both high.
  assign req = cyc_i && stb_i;

  // The write lands on the edge where the master sees ack high, never earlier.
  assign wr_now = req && we_i && ack_o;

  // Ack rises one cycle after the request and drops the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req && !ack_o;
    end
  end

  // Read data; unmapped offsets and the command register read as zero.
  always_comb begin
    next_dat = trig_filter_pkg::RST_ZERO;
    case (adr_i)
      trig_filter_pkg::OFS_FILT_FN: next_dat = filt_fn;
      trig_filter_pkg::OFS_FILT_BUS: next_dat[trig_filter_pkg::FILT_BUS_W-1:0] = filt_bus;
      trig_filter_pkg::OFS_ROUTE_SEL: next_dat = route_sel;
      trig_filter_pkg::OFS_ROUTE_EN: next_dat[trig_filter_pkg::ROUTE_EN_W-1:0] = route_en;
      trig_filter_pkg::OFS_TRIG_CFG: next_dat[trig_filter_pkg::TRIG_CFG_W-1:0] = trig_cfg;
      trig_filter_pkg::OFS_STATUS: next_dat[trig_filter_pkg::NUM_IN-1:0] = filt_all;
      trig_filter_pkg::OFS_RAW: next_dat[trig_filter_pkg::NUM_IN-1:0] = raw_all;
      default: next_dat = trig_filter_pkg::RST_ZERO;
    endcase
  end

  // Read data is captured together with the rising ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= trig_filter_pkg::RST_ZERO;
    end else if (req && !ack_o) begin
      dat_o <= next_dat;
    end
  end

  // ==========================================================================
  // Filter setting registers

  // Two bits per input; reset clears all to disabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_fn <= trig_filter_pkg::RST_ZERO;
      filt_bus <= '0;
    end else if (wr_now && adr_i == trig_filter_pkg::OFS_FILT_FN) begin
      filt_fn <= merge(filt_fn, dat_i, sel_i);
    end else if (wr_now && adr_i == trig_filter_pkg::OFS_FILT_BUS) begin
      filt_bus <= trig_filter_pkg::FILT_BUS_W'(merge(32'(filt_bus), dat_i, sel_i));
    end
  end

  // ==========================================================================
  // Routing registers

  // Per bused line a four-bit function input select, plus drive enables.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route_sel <= trig_filter_pkg::RST_ZERO;
      route_en <= '0;
    end else if (wr_now && adr_i == trig_filter_pkg::OFS_ROUTE_SEL) begin
      route_sel <= merge(route_sel, dat_i, sel_i);
    end else if (wr_now && adr_i == trig_filter_pkg::OFS_ROUTE_EN) begin
      route_en <= trig_filter_pkg::ROUTE_EN_W'(merge(32'(route_en), dat_i, sel_i));
    end
  end

  // ==========================================================================
  // Trigger configuration and software command

  // Source code, edge, enable and target mask.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_cfg <= '0;
    end else if (wr_now && adr_i == trig_filter_pkg::OFS_TRIG_CFG) begin
      trig_cfg <= trig_filter_pkg::TRIG_CFG_W'(merge(32'(trig_cfg), dat_i, sel_i));
    end
  end

  // Writing one to bit 0 of the command register fires one software trigger.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_pulse <= 1'b0;
    end else begin
      sw_pulse <= wr_now && adr_i == trig_filter_pkg::OFS_TRIG_CMD && sel_i[0] && dat_i[0];
    end
  end

  // ==========================================================================
  // Per-input debounce filters

  // Inputs are packed function, then bused, then star.
  assign raw_all = {star_trigger_line_i, bused_trigger_line_i, function_input_i};
  assign setting_all = {filt_bus, filt_fn};

  generate
    for (genvar i = 0; i < trig_filter_pkg::NUM_IN; i++) begin : g_filt
      // Each filter owns its setting bits, so settings never interact.
      debounce_filter #(
        .LONG_CYCLES(LONG_CYCLES)
      ) u_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(raw_all[i]),
        .setting_i(setting_all[2*i +: 2]),
        .filt_o(filt_all[i])
      );
    end
  endgenerate

  // Filtered levels leave straight from the filter flops.
  assign filtered_function_o = filt_all[trig_filter_pkg::NUM_FN-1:0];
  assign filtered_bused_o = filt_all[trig_filter_pkg::NUM_FN +: trig_filter_pkg::NUM_BUS];
  assign filtered_star_o = filt_all[trig_filter_pkg::STAR_IDX];

  // ==========================================================================
  // Raw routing between function pins and bused lines

  // Direct routes use raw pins so a route adds no filter delay.
  // The star line has no output path at all, so it can never be driven.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bused_trigger_line_o <= '0;
      bused_trigger_line_oe_n_o <= '1;
      function_input_o <= '0;
      function_input_oe_n_o <= '1;
    end else begin
      for (int k = 0; k < trig_filter_pkg::NUM_BUS; k++) begin
        bused_trigger_line_o[k] <= function_input_i[route_sel[4*k +: 4]];
        bused_trigger_line_oe_n_o[k] <= !route_en[k];
      end
      for (int j = 0; j < trig_filter_pkg::NUM_FN; j++) begin
        function_input_o[j] <= bused_trigger_line_i[j % trig_filter_pkg::NUM_BUS];
        function_input_oe_n_o[j] <= !route_en[trig_filter_pkg::NUM_BUS + j];
      end
    end
  end

  // ==========================================================================
  // Digital trigger source and edge

  assign src_code = trig_cfg[trig_filter_pkg::TRIG_SRC_LSB +: 5];

  // Codes 0-15 function inputs, 16-22 bused lines 0-6, 23 star; others idle low.
  always_comb begin
    if (src_code < trig_filter_pkg::SRC_STAR) begin
      src_level = filt_all[src_code];
    end else if (src_code == trig_filter_pkg::SRC_STAR) begin
      src_level = filt_all[trig_filter_pkg::STAR_IDX];
    end else begin
      src_level = 1'b0;
    end
  end

  trigger_edge_detect u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(src_level),
    .fall_i(trig_cfg[trig_filter_pkg::TRIG_FALL_BIT]),
    .en_i(trig_cfg[trig_filter_pkg::TRIG_EN_BIT]),
    .pulse_o(hw_pulse)
  );

  // Either trigger kind reaches every target whose mask bit is set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ai_trigger_o <= 1'b0;
      ao_trigger_o <= 1'b0;
      ctr_trigger_o <= 1'b0;
    end else begin
      ai_trigger_o <= (hw_pulse || sw_pulse) && trig_cfg[trig_filter_pkg::TRIG_AI_BIT];
      ao_trigger_o <= (hw_pulse || sw_pulse) && trig_cfg[trig_filter_pkg::TRIG_AO_BIT];
      ctr_trigger_o <= (hw_pulse || sw_pulse) && trig_cfg[trig_filter_pkg::TRIG_CTR_BIT];
    end
  end

  // ==========================================================================
  // Checks

  chk_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack was not a single cycle one clock after the request");
  chk_route_raw_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    route_en[0] |=> bused_trigger_line_o[0] == $past(function_input_i[route_sel[3:0]]) && !bused_trigger_line_oe_n_o[0])
    else $error("routed bused line did not carry the raw function input");
  chk_sw_trigger_ai: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_now && adr_i == trig_filter_pkg::OFS_TRIG_CMD && sel_i[0] && dat_i[0]
      && trig_cfg[trig_filter_pkg::TRIG_AI_BIT] |=> ##1 ai_trigger_o)
    else $error("software command did not trigger acquisition");

endmodule

// ---- verif/trig_source_model.sv ----
// Behavioural model of the backplane trigger lines and the external sources.
`timescale 1ns/1ns
module trig_source_model (
  // Levels the outside world puts on each line.
  input wire logic [15:0] want_fn_i,
  input wire logic [7:0] want_bus_i,
  input wire logic want_star_i,
  // Device drive values and enables, low means driving.
  input wire logic [15:0] dev_fn_i,
  input wire logic [15:0] dev_fn_oe_n_i,
  input wire logic [7:0] dev_bus_i,
  input wire logic [7:0] dev_bus_oe_n_i,
  // Resolved wire levels and the slot reference.
  output logic [15:0] fn_o,
  output logic [7:0] bus_o,
  output logic star_o,
  output logic ref_clk_o
);
  // ==========================================================================
  // Wire resolution
  // The source gives way wherever the device drives, so no line has two drivers.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      fn_o[i] = dev_fn_oe_n_i[i] ? want_fn_i[i] : dev_fn_i[i];
    end
    for (int i = 0; i < 8; i++) begin
      bus_o[i] = dev_bus_oe_n_i[i] ? want_bus_i[i] : dev_bus_i[i];
    end
  end
  // The star line is driven from this side alone.
  assign star_o = want_star_i;
  // Free-running 10 MHz slot reference; nothing in the block consumes it.
  initial ref_clk_o = 1'b0;
  always #50 ref_clk_o = ~ref_clk_o;
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the trigger input filter and edge trigger block.
`timescale 1ns/1ns
module tb;
  // ==========================================================================
  // Signals and bench state
  localparam int LONG_N = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, ai_trigger_o, ao_trigger_o, ctr_trigger_o, filtered_star_o, star_w, ref_clk;
  logic [15:0] want_fn = 16'h0, fn_w, fn_o, fn_oe_n, filtered_function_o;
  logic [7:0] want_bus = 8'h00, bus_w, bus_o, bus_oe_n, filtered_bused_o;
  logic want_star = 1'b0;
  logic [7:0] lfsr = 8'h4C;
  int cyc_n = 0, last_ack = 0, err_total = 0, cmp_count = 0;
  logic [31:0] rd_q[$];
  int trg_at[$];
  logic [2:0] trg_vec[$];
  // Trigger rows: source code, filter setting, falling select, target mask.
  int r_src[8] = '{5, 2, 15, 16, 22, 23, 9, 20};
  int r_set[8] = '{0, 1, 1, 2, 3, 1, 3, 0};
  int r_fall[8] = '{0, 0, 1, 0, 1, 0, 0, 1};
  int r_mask[8] = '{1, 2, 4, 1, 7, 5, 2, 1};
  int n_tab[4] = '{1, 3, 160, LONG_N};
  int sw_cfg[3] = '{32'h158, 32'h3D8, 32'h398};
  logic [2:0] sw_vec[3] = '{3'h2, 3'h7, 3'h7};

  // Clock and an edge count used to time every expected pulse.
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  trigger_input_debounce_edge_detect #(.LONG_CYCLES(LONG_N)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .function_input_i(fn_w), .function_input_o(fn_o), .function_input_oe_n_o(fn_oe_n),
    .bused_trigger_line_i(bus_w), .bused_trigger_line_o(bus_o), .bused_trigger_line_oe_n_o(bus_oe_n),
    .star_trigger_line_i(star_w), .filtered_function_o(filtered_function_o), .filtered_bused_o(filtered_bused_o),
    .filtered_star_o(filtered_star_o), .ai_trigger_o(ai_trigger_o), .ao_trigger_o(ao_trigger_o),
    .ctr_trigger_o(ctr_trigger_o));
  trig_source_model far (.want_fn_i(want_fn), .want_bus_i(want_bus), .want_star_i(want_star), .dev_fn_i(fn_o),
    .dev_fn_oe_n_i(fn_oe_n), .dev_bus_i(bus_o), .dev_bus_oe_n_i(bus_oe_n), .fn_o(fn_w), .bus_o(bus_w),
    .star_o(star_w), .ref_clk_o(ref_clk));

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic cmp_trig(input int exp_at, input logic [2:0] exp_vec);
    cmp_count++;
    if (exp_at != cyc_n || exp_vec !== {ai_trigger_o, ao_trigger_o, ctr_trigger_o}) begin
      err_total++;
      $display("MISMATCH %0t: trigger pulse at edge %0d, wanted %0d", $time, cyc_n, exp_at);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled, then drops for a cycle.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= adr;
    sel_i <= sel;
    dat_i <= dat;
    // Only the watchdog ends a wait for an answer that never comes.
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    last_ack = cyc_n;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb(1'b0, adr, 4'hF, 32'h0);
  endtask

  task automatic note(input int at, input logic [2:0] v);
    trg_at.push_back(at);
    trg_vec.push_back(v);
  endtask

  task automatic drive(input int src, input logic v);
    if (src < 16)
      want_fn[src] <= v;
    else if (src < 23)
      want_bus[src - 16] <= v;
    else
      want_star <= v;
  endtask

  // A pulse of w samples away from idle; a passing one is due N plus 3 edges later.
  task automatic pulse(input int src, input logic idle, input int w, input logic [2:0] m);
    if (w > 0) begin
      @(posedge clk_i);
      drive(src, ~idle);
      if (m != 3'h0)
        note(cyc_n + w + 3, m);
      repeat (w) @(posedge clk_i);
      drive(src, idle);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Result monitor: each answer takes the oldest note off its queue.
  always @(posedge clk_i) begin
    if (rst_i === 1'b0) begin
      if (ack_o === 1'b1 && we_i === 1'b0)
        cmp_word(rd_q.size() > 0 ? rd_q.pop_front() : 32'hDEAD_BEEF, dat_o);
      if ((ai_trigger_o | ao_trigger_o | ctr_trigger_o) !== 1'b0) begin
        if (trg_at.size() == 0)
          cmp_trig(-1, 3'h0);
        else
          cmp_trig(trg_at.pop_front(), trg_vec.pop_front());
      end
    end
  end

  // Watchdog sized well above the few thousand cycles the sequence needs.
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    close_out();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [2:0] m;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Every register, the unmapped word included, reads zero after reset.
    for (int a = 0; a <= 32; a += 4)
      rd(8'(a), 32'h0);
    // Random levels show up unfiltered in both level registers.
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_next(lfsr);
      want_fn[7:0] <= lfsr;
      lfsr = lfsr_next(lfsr);
      want_fn[15:8] <= lfsr;
      lfsr = lfsr_next(lfsr);
      want_bus <= lfsr;
      want_star <= lfsr[3];
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      cmp_word(32'({filtered_star_o, filtered_bused_o, filtered_function_o}), 32'({want_star, want_bus, want_fn}));
      rd(trig_filter_pkg::OFS_RAW, {7'h00, want_star, want_bus, want_fn});
      rd(trig_filter_pkg::OFS_STATUS, {7'h00, want_star, want_bus, want_fn});
    end
    want_fn <= 16'h0;
    want_bus <= 8'h00;
    want_star <= 1'b0;
    // Byte lanes, unmapped writes and the self-clearing command word.
    wb(1'b1, trig_filter_pkg::OFS_FILT_FN, 4'h2, 32'hFFFF_FFFF);
    rd(trig_filter_pkg::OFS_FILT_FN, 32'h0000_FF00);
    wb(1'b1, 8'h20, 4'hF, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    rd(trig_filter_pkg::OFS_TRIG_CMD, 32'h0);
    // Raw routing ignores a long filter; a neighbour without filter is unaffected.
    wb(1'b1, trig_filter_pkg::OFS_FILT_FN, 4'hF, 32'h0000_00C0);
    wb(1'b1, trig_filter_pkg::OFS_ROUTE_SEL, 4'hF, 32'h0000_0003);
    wb(1'b1, trig_filter_pkg::OFS_ROUTE_EN, 4'hF, 32'h0000_0201);
    want_fn[4:3] <= 2'b11;
    want_bus[1] <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    cmp_word(32'({bus_oe_n[0], bus_o[0], fn_oe_n[1], fn_o[1], filtered_function_o[4:3]}), 32'h16);
    @(posedge clk_i);
    want_fn <= 16'h0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    cmp_word(32'({bus_o[0], filtered_function_o[3]}), 32'h0);
    wb(1'b1, trig_filter_pkg::OFS_ROUTE_EN, 4'hF, 32'h0);
    want_bus <= 8'h00;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    cmp_word(32'({fn_oe_n, bus_oe_n}), 32'h00FF_FFFF);
    wb(1'b1, trig_filter_pkg::OFS_FILT_FN, 4'hF, 32'h0);
    // Each row: a pulse one sample short, a one-sample gap, then a pulse of exactly N.
    for (int i = 0; i < 8; i++) begin
      m = 3'(r_mask[i]);
      if (r_src[i] < 16) begin
        wb(1'b1, trig_filter_pkg::OFS_FILT_FN, 4'hF, 32'(r_set[i]) << (2 * r_src[i]));
      end else begin
        wb(1'b1, trig_filter_pkg::OFS_FILT_BUS, 4'hF,
          32'(r_set[i]) << (2 * (r_src[i] - 16 + int'(r_src[i] == 23))));
      end
      drive(r_src[i], r_fall[i][0]);
      repeat (200) @(posedge clk_i);
      wb(1'b1, trig_filter_pkg::OFS_TRIG_CFG, 4'hF, 32'(r_src[i] + 64 + 32 * r_fall[i] + 128 * r_mask[i]));
      pulse(r_src[i], r_fall[i][0], n_tab[r_set[i]] - 1, 3'h0);
      pulse(r_src[i], r_fall[i][0], n_tab[r_set[i]], {m[0], m[1], m[2]});
      repeat (n_tab[r_set[i]] + 10) @(posedge clk_i);
      wb(1'b1, trig_filter_pkg::OFS_TRIG_CFG, 4'hF, 32'h0);
      drive(r_src[i], 1'b0);
    end
    // Software triggers through each mask; the last has the edge enable off, which must not gate them.
    for (int s = 0; s < 3; s++) begin
      wb(1'b1, trig_filter_pkg::OFS_TRIG_CFG, 4'hF, 32'(sw_cfg[s]));
      wb(1'b1, trig_filter_pkg::OFS_TRIG_CMD, 4'hF, 32'h1);
      if (sw_vec[s] != 3'h0)
        note(last_ack + 2, sw_vec[s]);
      repeat (5) @(posedge clk_i);
    end
    repeat (20) @(posedge clk_i);
    cmp_word(32'(trg_at.size()), 32'h0);
    close_out();
  end
endmodule
